// ### rtl/homing_pkg.sv
// Constants shared by the homing sequencer: register map, status bits,
// segment encoding and method codes.
// Assumes a plain single-word register port with 8-bit byte addresses.
package homing_pkg;

   // ----------------------------------------------------------------
   // Register map, byte addresses of aligned 32-bit words
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STAT   = 8'h04;
   localparam logic [7:0] ADDR_METHOD = 8'h08;
   localparam logic [7:0] ADDR_VHIGH  = 8'h0c;
   localparam logic [7:0] ADDR_VLOW   = 8'h10;
   localparam logic [7:0] ADDR_ACCEL  = 8'h14;

   // ----------------------------------------------------------------
   // Control and status word bit positions
   // ----------------------------------------------------------------
   localparam int CW_START   = 4;
   localparam int SW_ABN     = 8;
   localparam int SW_REACHED = 10;
   localparam int SW_DONE    = 12;
   localparam int SW_ERR     = 13;
   localparam int SW_PZERO   = 14;
   localparam int SW_TRIG    = 15;
   localparam int CW_W       = 16;
   localparam int METH_W     = 8;

   // ----------------------------------------------------------------
   // Segment word: {dir, fast, sig[1:0], level, final}
   // ----------------------------------------------------------------
   localparam int SEG_W   = 6;
   localparam int SEG_DIR = 5;
   localparam int SEG_FST = 4;
   localparam int SEG_SHI = 3;
   localparam int SEG_SLO = 2;
   localparam int SEG_LVL = 1;
   localparam int SEG_FIN = 0;

   localparam logic       POS  = 1'b1;
   localparam logic       NEG  = 1'b0;
   localparam logic       FAST = 1'b1;
   localparam logic       SLOW = 1'b0;
   localparam logic [1:0] HOME = 2'h0;
   localparam logic [1:0] PLIM = 2'h1;
   localparam logic [1:0] NLIM = 2'h2;

   // Branch of a method's sequence
   localparam logic [1:0] BR_A = 2'h0;
   localparam logic [1:0] BR_B = 2'h1;
   localparam logic [1:0] BR_C = 2'h2;
   localparam logic [2:0] STEP_FIRST  = 3'h0;
   localparam logic [2:0] STEP_C_BACK = 3'h1;

   // Supported method codes
   localparam logic [7:0] METH_NLIM    = 8'h01;
   localparam logic [7:0] METH_PLIM    = 8'h02;
   localparam logic [7:0] METH_SW_LO   = 8'h03;
   localparam logic [7:0] METH_SW_HI   = 8'h06;
   localparam logic [7:0] METH_COMB_LO = 8'h07;
   localparam logic [7:0] METH_COMB_HI = 8'h0a;

   typedef enum logic [1:0] {ST_IDLE, ST_MOVE, ST_REACHED} hm_state_t;

endpackage

// ### rtl/homing_sequencer.sv
// Homing sequencer for one servo axis: switch and index based methods.
// Assumes switch and index pins are asynchronous, active high, and that
// the motion stage follows mot_run, mot_dir and mot_vel every cycle.
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps

// Function
// - Method 1 clear: negative fast, positive slow
// - Method 1 on limit: leave, return, slow
// - Method 1 positive limit: error, halt
// - Method 2 clear: positive fast, negative slow
// - Method 2 on limit: leave, return, slow
// - Method 2 negative limit: error, halt
// - Method 3 sequences around homing switch
// - Method 4 sequences around homing switch
// - Method 5 sequences around homing switch
// - Method 6 sequences around homing switch
// - Methods 3 to 6: any limit errors
// - Method 7 with limit reversal branch
// - Method 8 with limit reversal branch
// - Method 9 with limit reversal branch
// - Method 10 clear start sequence
// - Methods 7 to 10: negative limit errors
// - Start bit rise starts, fall halts
// - Done flag only after target reached
// - Zero parameter raises status bit 14
module homing_sequencer (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        lim_pos,
   input  wire logic        lim_neg,
   input  wire logic        home_sw,
   input  wire logic        enc_idx,
   output logic             mot_run,
   output logic             mot_dir,
   output logic      [31:0] mot_vel,
   output logic             hm_done,
   output logic             hm_err
);

   // Short local names for the segment table fields
   localparam logic       POS_C  = homing_pkg::POS;
   localparam logic       NEG_C  = homing_pkg::NEG;
   localparam logic       FAST_C = homing_pkg::FAST;
   localparam logic       SLOW_C = homing_pkg::SLOW;
   localparam logic [1:0] HOME_C = homing_pkg::HOME;
   localparam logic [1:0] PLIM_C = homing_pkg::PLIM;
   localparam logic [1:0] NLIM_C = homing_pkg::NLIM;

   // ----------------------------------------------------------------
   // Segment table
   // ----------------------------------------------------------------
   function automatic logic [5:0] mk(input logic d, input logic f,
                                     input logic [1:0] sg, input logic l,
                                     input logic fn);
      mk = {d, f, sg, l, fn};
   endfunction

   // Index is {branch, step}; the final entry of each path is slow
   function automatic logic [5:0] seg_of(input logic [7:0] m,
                                         input logic [1:0] br,
                                         input logic [2:0] st);
      logic [5:0] s;
      s = mk(NEG_C, SLOW_C, HOME_C, 1'b0, 1'b1);
      case (m)
         8'h01: case ({br, st})
            5'h00: s = mk(NEG_C, FAST_C, NLIM_C, 1'b1, 1'b0);
            5'h08: s = mk(POS_C, FAST_C, NLIM_C, 1'b0, 1'b0);
            5'h09: s = mk(NEG_C, FAST_C, NLIM_C, 1'b1, 1'b0);
            default: s = mk(POS_C, SLOW_C, NLIM_C, 1'b0, 1'b1);
         endcase
         8'h02: case ({br, st})
            5'h00: s = mk(POS_C, FAST_C, PLIM_C, 1'b1, 1'b0);
            5'h08: s = mk(NEG_C, FAST_C, PLIM_C, 1'b0, 1'b0);
            5'h09: s = mk(POS_C, FAST_C, PLIM_C, 1'b1, 1'b0);
            default: s = mk(NEG_C, SLOW_C, PLIM_C, 1'b0, 1'b1);
         endcase
         8'h03, 8'h07: case ({br, st})
            5'h00: s = mk(POS_C, FAST_C, HOME_C, 1'b1, 1'b0);
            5'h08: s = mk(NEG_C, FAST_C, HOME_C, 1'b0, 1'b0);
            5'h09: s = mk(POS_C, FAST_C, HOME_C, 1'b1, 1'b0);
            5'h11: s = mk(NEG_C, FAST_C, HOME_C, 1'b1, 1'b0);
            5'h12: s = mk(NEG_C, FAST_C, HOME_C, 1'b0, 1'b0);
            5'h13: s = mk(POS_C, FAST_C, HOME_C, 1'b1, 1'b0);
            default: s = mk(NEG_C, SLOW_C, HOME_C, 1'b0, 1'b1);
         endcase
         8'h04, 8'h08: case ({br, st})
            5'h00: s = mk(POS_C, FAST_C, HOME_C, 1'b1, 1'b0);
            5'h01: s = mk(NEG_C, FAST_C, HOME_C, 1'b0, 1'b0);
            5'h08: s = mk(NEG_C, FAST_C, HOME_C, 1'b0, 1'b0);
            5'h11: s = mk(NEG_C, FAST_C, HOME_C, 1'b1, 1'b0);
            5'h12: s = mk(NEG_C, FAST_C, HOME_C, 1'b0, 1'b0);
            default: s = mk(POS_C, SLOW_C, HOME_C, 1'b1, 1'b1);
         endcase
         8'h05: case ({br, st})
            5'h00: s = mk(NEG_C, FAST_C, HOME_C, 1'b1, 1'b0);
            5'h08: s = mk(POS_C, FAST_C, HOME_C, 1'b0, 1'b0);
            5'h09: s = mk(NEG_C, FAST_C, HOME_C, 1'b1, 1'b0);
            default: s = mk(POS_C, SLOW_C, HOME_C, 1'b0, 1'b1);
         endcase
         8'h06: case ({br, st})
            5'h00: s = mk(NEG_C, FAST_C, HOME_C, 1'b1, 1'b0);
            5'h01: s = mk(POS_C, FAST_C, HOME_C, 1'b0, 1'b0);
            5'h08: s = mk(POS_C, FAST_C, HOME_C, 1'b0, 1'b0);
            default: s = mk(NEG_C, SLOW_C, HOME_C, 1'b1, 1'b1);
         endcase
         8'h09: case ({br, st})
            5'h00: s = mk(POS_C, FAST_C, HOME_C, 1'b1, 1'b0);
            5'h01: s = mk(POS_C, FAST_C, HOME_C, 1'b0, 1'b0);
            5'h08: s = mk(POS_C, FAST_C, HOME_C, 1'b0, 1'b0);
            5'h11: s = mk(NEG_C, FAST_C, HOME_C, 1'b1, 1'b0);
            5'h12: s = mk(POS_C, FAST_C, HOME_C, 1'b0, 1'b0);
            default: s = mk(NEG_C, SLOW_C, HOME_C, 1'b1, 1'b1);
         endcase
         8'h0a: case ({br, st})
            5'h00: s = mk(POS_C, FAST_C, HOME_C, 1'b1, 1'b0);
            5'h01: s = mk(POS_C, FAST_C, HOME_C, 1'b0, 1'b0);
            5'h02: s = mk(NEG_C, FAST_C, HOME_C, 1'b1, 1'b0);
            5'h08: s = mk(POS_C, FAST_C, HOME_C, 1'b0, 1'b0);
            5'h09: s = mk(NEG_C, FAST_C, HOME_C, 1'b1, 1'b0);
            5'h11: s = mk(NEG_C, FAST_C, HOME_C, 1'b1, 1'b0);
            default: s = mk(POS_C, SLOW_C, HOME_C, 1'b0, 1'b1);
         endcase
         default: s = mk(NEG_C, SLOW_C, HOME_C, 1'b0, 1'b1);
      endcase
      seg_of = s;
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers: a change counts once stages two and three agree
   // ----------------------------------------------------------------
   logic [3:0] sync1_q, sync2_q, sync3_q, filt_q, filt_prev_q;
   wire  [3:0] pins   = {enc_idx, home_sw, lim_neg, lim_pos};
   wire  [3:0] filt_d = (sync2_q & sync3_q) | (filt_q & (sync2_q ^ sync3_q));

   always_ff @(posedge sys_clk) begin
      sync1_q     <= pins;
      sync2_q     <= sync1_q;
      sync3_q     <= sync2_q;
      filt_q      <= rst_n ? filt_d : 4'h0;
      filt_prev_q <= rst_n ? filt_q : 4'h0;
   end

   wire plim_s  = filt_q[0];
   wire nlim_s  = filt_q[1];
   wire home_s  = filt_q[2];
   wire idx_rise = filt_q[3] & ~filt_prev_q[3];

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------
   logic [15:0] ctrl_q;
   logic [7:0]  method_q;
   logic [31:0] vhigh_q, vlow_q, accel_q;
   logic        start_prev_q;

   wire wr_ctrl   = reg_wr && reg_addr == homing_pkg::ADDR_CTRL;
   wire wr_method = reg_wr && reg_addr == homing_pkg::ADDR_METHOD;
   wire wr_vhigh  = reg_wr && reg_addr == homing_pkg::ADDR_VHIGH;
   wire wr_vlow   = reg_wr && reg_addr == homing_pkg::ADDR_VLOW;
   wire wr_accel  = reg_wr && reg_addr == homing_pkg::ADDR_ACCEL;

   // Config registers; a change mid-run takes effect from the next cycle, within the current segment
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ctrl_q       <= 16'h0000;
         method_q     <= 8'h00;
         vhigh_q      <= 32'h0000_0000;
         vlow_q       <= 32'h0000_0000;
         accel_q      <= 32'h0000_0000;
         start_prev_q <= 1'b0;
      end else begin
         if (wr_ctrl)   ctrl_q   <= reg_wdata[homing_pkg::CW_W-1:0];
         if (wr_method) method_q <= reg_wdata[homing_pkg::METH_W-1:0];
         if (wr_vhigh)  vhigh_q  <= reg_wdata;
         if (wr_vlow)   vlow_q   <= reg_wdata;
         if (wr_accel)  accel_q  <= reg_wdata;
         start_prev_q <= ctrl_q[homing_pkg::CW_START];
      end
   end

   wire start_rise = ctrl_q[homing_pkg::CW_START] & ~start_prev_q;
   wire start_fall = ~ctrl_q[homing_pkg::CW_START] & start_prev_q;
   wire pzero      = method_q == 8'h00 || vhigh_q == 32'h0000_0000 ||
                     vlow_q == 32'h0000_0000 || accel_q == 32'h0000_0000;

   // ----------------------------------------------------------------
   // Method decode
   // ----------------------------------------------------------------
   wire m_nlim  = method_q == homing_pkg::METH_NLIM;
   wire m_plim  = method_q == homing_pkg::METH_PLIM;
   wire m_sw    = method_q >= homing_pkg::METH_SW_LO && method_q <= homing_pkg::METH_SW_HI;
   wire m_comb  = method_q >= homing_pkg::METH_COMB_LO && method_q <= homing_pkg::METH_COMB_HI;
   wire m_valid = m_nlim | m_plim | m_sw | m_comb;

   // Unexpected limit per method family
   wire lim_err = (m_nlim & plim_s)
                | (m_plim & nlim_s)
                | (m_sw & (plim_s | nlim_s))
                | (m_comb & nlim_s);

   // Start branch from one sample of the switches
   wire [1:0] start_br = (m_nlim & nlim_s) | (m_plim & plim_s) | ((m_sw | m_comb) & home_s)
                         ? homing_pkg::BR_B
                         : (m_comb & plim_s) ? homing_pkg::BR_C : homing_pkg::BR_A;
   wire [2:0] start_st = (start_br == homing_pkg::BR_C) ? homing_pkg::STEP_C_BACK
                                                        : homing_pkg::STEP_FIRST;

   // ----------------------------------------------------------------
   // Sequencer next state
   // ----------------------------------------------------------------
   homing_pkg::hm_state_t state_q, state_d;
   logic [1:0] br_q, br_d;
   logic [2:0] step_q, step_d;
   logic       armed_q, armed_d;
   logic       reached_q, reached_d, done_q, done_d, err_q, err_d, abn_q, abn_d;

   wire [5:0] seg     = seg_of(method_q, br_q, step_q);
   wire [1:0] seg_sig = seg[homing_pkg::SEG_SHI:homing_pkg::SEG_SLO];
   wire       seg_lvl = seg[homing_pkg::SEG_LVL];
   wire       seg_fin = seg[homing_pkg::SEG_FIN];
   wire       sig_now = seg_sig == HOME_C ? home_s : seg_sig == PLIM_C ? plim_s : nlim_s;
   wire       sig_was = seg_sig == HOME_C ? filt_prev_q[2]
                      : seg_sig == PLIM_C ? filt_prev_q[0] : filt_prev_q[1];
   wire       sig_edge = sig_now == seg_lvl && sig_was != seg_lvl;
   // Positive limit in combined methods reverses before the final segment and outside branch C, instead of faulting
   wire       rev_hit  = m_comb & plim_s & ~seg_fin & br_q != homing_pkg::BR_C;

   always_comb begin
      state_d   = state_q;
      br_d      = br_q;
      step_d    = step_q;
      armed_d   = armed_q;
      reached_d = reached_q;
      done_d    = done_q;
      err_d     = err_q;
      abn_d     = abn_q;
      unique case (state_q)
         homing_pkg::ST_IDLE: begin
            if (start_rise && !pzero) begin
               err_d     = ~m_valid;
               abn_d     = 1'b0;
               reached_d = 1'b0;
               done_d    = 1'b0;
               armed_d   = 1'b0;
               br_d      = start_br;
               step_d    = start_st;
               if (m_valid) state_d = homing_pkg::ST_MOVE;
            end
         end
         homing_pkg::ST_MOVE: begin
            if (start_fall) begin
               state_d = homing_pkg::ST_IDLE;
            end else if (lim_err) begin
               err_d   = 1'b1;
               abn_d   = 1'b1;
               state_d = homing_pkg::ST_IDLE;
            end else if (rev_hit) begin
               br_d    = homing_pkg::BR_C;
               step_d  = homing_pkg::STEP_C_BACK;
            end else if (!seg_fin) begin
               if (sig_now == seg_lvl) step_d = step_q + 3'h1;
            end else if (armed_q && idx_rise) begin
               reached_d = 1'b1;
               state_d   = homing_pkg::ST_REACHED;
            end else if (sig_edge) begin
               armed_d = 1'b1;
            end
         end
         homing_pkg::ST_REACHED: begin
            done_d  = reached_q;
            state_d = homing_pkg::ST_IDLE;
         end
         default: state_d = homing_pkg::ST_IDLE;
      endcase
   end

   // Sequencer and status flops
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_q   <= homing_pkg::ST_IDLE;
         br_q      <= homing_pkg::BR_A;
         step_q    <= homing_pkg::STEP_FIRST;
         armed_q   <= 1'b0;
         reached_q <= 1'b0;
         done_q    <= 1'b0;
         err_q     <= 1'b0;
         abn_q     <= 1'b0;
      end else begin
         state_q   <= state_d;
         br_q      <= br_d;
         step_q    <= step_d;
         armed_q   <= armed_d;
         reached_q <= reached_d;
         done_q    <= done_d;
         err_q     <= err_d;
         abn_q     <= abn_d;
      end
   end

   // ----------------------------------------------------------------
   // Motion command outputs, registered from the next segment
   // ----------------------------------------------------------------
   wire [5:0] seg_nx = seg_of(method_q, br_d, step_d);
   wire       run_nx = state_d == homing_pkg::ST_MOVE;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mot_run <= 1'b0;
         mot_dir <= 1'b0;
         mot_vel <= 32'h0000_0000;
         hm_done <= 1'b0;
         hm_err  <= 1'b0;
      end else begin
         mot_run <= run_nx;
         mot_dir <= seg_nx[homing_pkg::SEG_DIR];
         mot_vel <= !run_nx ? 32'h0000_0000 : seg_nx[homing_pkg::SEG_FST] ? vhigh_q : vlow_q;
         hm_done <= done_d;
         hm_err  <= err_d;
      end
   end

   // ----------------------------------------------------------------
   // Read port, data one cycle after the strobe, unmapped reads zero
   // ----------------------------------------------------------------
   logic [15:0] stat;
   always_comb begin
      stat                        = 16'h0000;
      stat[homing_pkg::SW_ABN]     = abn_q;
      stat[homing_pkg::SW_REACHED] = reached_q;
      stat[homing_pkg::SW_DONE]    = done_q;
      stat[homing_pkg::SW_ERR]     = err_q;
      stat[homing_pkg::SW_PZERO]   = pzero;
      stat[homing_pkg::SW_TRIG]    = state_q == homing_pkg::ST_MOVE;
   end

   wire [31:0] rd_mux = reg_addr == homing_pkg::ADDR_CTRL   ? {16'h0000, ctrl_q}
                      : reg_addr == homing_pkg::ADDR_STAT   ? {16'h0000, stat}
                      : reg_addr == homing_pkg::ADDR_METHOD ? {24'h000000, method_q}
                      : reg_addr == homing_pkg::ADDR_VHIGH  ? vhigh_q
                      : reg_addr == homing_pkg::ADDR_VLOW   ? vlow_q
                      : reg_addr == homing_pkg::ADDR_ACCEL  ? accel_q : 32'h0000_0000;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) reg_rdata <= 32'h0000_0000;
      else        reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
   end

endmodule

// ### tb/axis_model.sv
// Behavioural axis: position from velocity, limit and homing switches, index.
// Assumes mot_vel counts eighths of a step per cycle; the bench loads position.
`timescale 1ns/1ps
module axis_model (
   input  wire logic               sys_clk,
   input  wire logic               mot_run,
   input  wire logic               mot_dir,
   input  wire logic        [31:0] mot_vel,
   input  wire logic               load,
   input  wire logic signed [31:0] load_pos,
   output logic                    lim_pos,
   output logic                    lim_neg,
   output logic                    home_sw,
   output logic                    enc_idx,
   output int                      pos
);
   int acc_q;
   // Integrator: slow speed dwells eight cycles per step, so the index outlives the filter
   always_ff @(posedge sys_clk) begin
      if (load) begin
         pos <= load_pos;
         acc_q <= 0;
      end else if (mot_run) begin
         pos <= (acc_q + int'(mot_vel) < 8) ? pos : (mot_dir ? pos + 1 : pos - 1);
         acc_q <= (acc_q + int'(mot_vel)) % 8;
      end
   end
   // Switch bands; an index mark every 32 steps
   assign lim_pos = pos >= 200;
   assign lim_neg = pos <= -200;
   assign home_sw = pos >= 40 && pos <= 80;
   assign enc_idx = pos % 32 == 0;
endmodule

// ### tb/homing_sequencer_checker.sv
// Port checker for the homing sequencer, bound after the module.
// Assumes the register map and method codes of homing_pkg.
`timescale 1ns/1ps
module homing_sequencer_checker (
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        lim_pos,
   input wire logic        lim_neg,
   input wire logic        mot_run,
   input wire logic        hm_done,
   input wire logic        hm_err
);
   logic [7:0] meth_q;
   wire        stat_rd = reg_rd && reg_addr == homing_pkg::ADDR_STAT;
   // Method shadow, since the limit rules depend on the method
   always_ff @(posedge sys_clk) begin
      if (!rst_n)
         meth_q <= 8'h00;
      else if (reg_wr && reg_addr == homing_pkg::ADDR_METHOD)
         meth_q <= reg_wdata[7:0];
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Seven samples cover the pin filter plus the output register
   sequence s_plim; lim_pos [*7]; endsequence
   sequence s_nlim; lim_neg [*7]; endsequence
   sequence s_alim; (lim_pos || lim_neg) [*7]; endsequence
   AST_PLIM_M1: assert property ((mot_run && meth_q == 8'h01) ##0 s_plim
      |=> hm_err && !mot_run) else $error("positive limit not flagged");
   AST_NLIM_M2: assert property ((mot_run && (meth_q == 8'h02 || meth_q inside {[8'h07:8'h0a]}))
      ##0 s_nlim |=> hm_err && !mot_run) else $error("negative limit not flagged");
   AST_ANY_LIM: assert property ((mot_run && meth_q inside {[8'h03:8'h06]}) ##0 s_alim
      |=> hm_err && !mot_run) else $error("limit not flagged in switch method");
   AST_ERR_HALT: assert property (hm_err |-> !mot_run)
      else $error("motor runs with error set");
   AST_DONE_AFTER: assert property ($rose(hm_done) |-> !mot_run && !$past(mot_run))
      else $error("done before target reached");
   AST_STOP_CLR: assert property (reg_wr && reg_addr == homing_pkg::ADDR_CTRL
      && !reg_wdata[4] && mot_run |-> ##[1:3] !mot_run) else $error("stop not obeyed");
   AST_START_CLEAN: assert property ($rose(mot_run) |-> !hm_err && !hm_done)
      else $error("stale flags at motion start");
   AST_PZERO: assert property (stat_rd && meth_q == 8'h00 |=> reg_rdata[14])
      else $error("zero method not reported");
endmodule
bind homing_sequencer homing_sequencer_checker checker_i (.sys_clk, .rst_n, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .lim_pos, .lim_neg, .mot_run, .hm_done, .hm_err);

// ### tb/homing_sequencer_test.sv
// Self-checking bench: homing runs against a behavioural axis.
// Assumes high speed 8 and low speed 1 in eighths of a step per cycle.
`timescale 1ns/1ps
module homing_sequencer_test;
   logic        sys_clk, rst_n, reg_wr, reg_rd, load, fault_pos, fault_neg, last_dir;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, rd_v, last_vel, load_pos;
   wire  [31:0] reg_rdata, mot_vel;
   wire         lim_pos, lim_neg, home_sw, enc_idx, mot_run, mot_dir, hm_done, hm_err;
   int          pos, n_errors, checked;
   // Stray limits are injected on top of the axis switches
   homing_sequencer dut (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .lim_pos(lim_pos | fault_pos), .lim_neg(lim_neg | fault_neg), .home_sw,
      .enc_idx, .mot_run, .mot_dir, .mot_vel, .hm_done, .hm_err);
   axis_model axis (.sys_clk, .mot_run, .mot_dir, .mot_vel, .load, .load_pos, .lim_pos,
      .lim_neg, .home_sw, .enc_idx, .pos);
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // ------------------------------------------------------------
   // Bus and checking tasks
   // ------------------------------------------------------------
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe edge
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 rd_v = reg_rdata;
   endtask
   // Place the axis, let the pin filters settle, then raise the start bit
   task automatic start_home(input logic [7:0] m, input logic [31:0] p, input logic run);
      load_pos <= p;
      load <= 1'b1;
      @(posedge sys_clk);
      load <= 1'b0;
      repeat (8) @(posedge sys_clk);
      wr(homing_pkg::ADDR_METHOD, {24'h0, m});
      wr(homing_pkg::ADDR_CTRL, 32'h0);
      wr(homing_pkg::ADDR_CTRL, 32'h10);
      repeat (2) @(posedge sys_clk);
      #1 chk("mot_run after start", 32'(run), 32'(mot_run));
      chk("hm_err after start", 32'h0, 32'(hm_err));
   endtask
   task automatic wait_end();
      int i;
      for (i = 0; i < 6000 && hm_done !== 1'b1 && hm_err !== 1'b1; i++) begin
         @(posedge sys_clk);
         #1;
         if (mot_run === 1'b1) begin
            last_dir = mot_dir;
            last_vel = mot_vel;
         end
      end
      if (i == 6000) begin
         chk("homing end", 32'h1, 32'h0);
         report_and_stop();
      end
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic test_regs();
      rd(homing_pkg::ADDR_STAT);
      chk("zero parameter flag", 32'h1, 32'(rd_v[homing_pkg::SW_PZERO]));
      wr(homing_pkg::ADDR_VHIGH, 32'h8);
      wr(homing_pkg::ADDR_VLOW, 32'h0);
      wr(homing_pkg::ADDR_ACCEL, 32'h1);
      start_home(homing_pkg::METH_NLIM, 32'h0, 1'b0);
      rd(homing_pkg::ADDR_STAT);
      chk("zero low speed flag", 32'h4000, rd_v & 32'h7000);
      rd(homing_pkg::ADDR_CTRL);
      chk("control readback", 32'h10, rd_v);
      rd(homing_pkg::ADDR_METHOD);
      chk("method readback", 32'h1, rd_v);
      rd(homing_pkg::ADDR_VHIGH);
      chk("high speed readback", 32'h8, rd_v);
      wr(homing_pkg::ADDR_VLOW, 32'h1);
      wr(homing_pkg::ADDR_STAT, 32'hffff);
      rd(homing_pkg::ADDR_STAT);
      chk("status after writes", 32'h0, rd_v & 32'h7000);
      rd(8'h40);
      chk("unmapped read", 32'h0, rd_v);
      $display("test_regs finished");
   endtask
   // Every method; branch B starts for methods 1 to 4 and 9, branch C by method 7 reversal; the stop index follows from the switch bands
   task automatic test_methods();
      int   m[16] = '{1, 1, 2, 2, 3, 3, 4, 4, 5, 6, 7, 7, 8, 9, 9, 10};
      int   s[16] = '{0, -210, 0, 210, 0, 60, 0, 60, 100, 100, 0, 100, 0, 0, 60, 0};
      int   e[16] = '{-192, -192, 192, 192, 32, 32, 64, 64, 96, 64, 32, 32, 64, 64, 64, 96};
      logic d[16] = '{1, 1, 0, 0, 0, 0, 1, 1, 1, 0, 0, 0, 1, 0, 0, 1};
      for (int i = 0; i < 16; i++) begin
         start_home(m[i][7:0], s[i], 1'b1);
         wait_end();
         chk("done flag", 32'h1, 32'(hm_done));
         chk("final direction", 32'(d[i]), 32'(last_dir));
         chk("final speed", 32'h1, last_vel);
         chk("stop position", e[i], pos);
         rd(homing_pkg::ADDR_STAT);
         chk("reached and done", 32'h1400, rd_v & 32'hb500);
      end
      $display("test_methods finished");
   endtask
   task automatic test_errors();
      int   m[5] = '{1, 2, 3, 4, 7};
      logic p[5] = '{1, 0, 0, 1, 0};
      for (int i = 0; i < 5; i++) begin
         start_home(m[i][7:0], 32'h0, 1'b1);
         repeat (30) @(posedge sys_clk);
         fault_pos <= p[i];
         fault_neg <= !p[i];
         repeat (10) @(posedge sys_clk);
         #1 chk("run on stray limit", 32'h0, 32'(mot_run));
         rd(homing_pkg::ADDR_STAT);
         chk("error status", 32'h2100, rd_v & 32'h3100);
         fault_pos <= 1'b0;
         fault_neg <= 1'b0;
      end
      $display("test_errors finished");
   endtask
   task automatic test_abort();
      start_home(homing_pkg::METH_NLIM, 32'h0, 1'b1);
      repeat (20) @(posedge sys_clk);
      rd(homing_pkg::ADDR_STAT);
      chk("homing in progress", 32'h8000, rd_v & 32'h8000);
      wr(homing_pkg::ADDR_CTRL, 32'h0);
      repeat (3) @(posedge sys_clk);
      #1 chk("run after stop", 32'h0, 32'(mot_run));
      chk("flags after stop", 32'h0, {30'h0, hm_done, hm_err});
      // Unsupported method code: error, no motion
      wr(homing_pkg::ADDR_METHOD, 32'h0b);
      wr(homing_pkg::ADDR_CTRL, 32'h10);
      repeat (2) @(posedge sys_clk);
      #1 chk("bad method error", 32'h1, 32'(hm_err));
      chk("bad method run", 32'h0, 32'(mot_run));
      $display("test_abort finished");
   endtask
   initial begin
      {rst_n, reg_wr, reg_rd, fault_pos, fault_neg, reg_addr, reg_wdata} = '0;
      {load, load_pos, n_errors, checked} = {1'b1, 32'h0, 32'h0, 32'h0};
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      test_regs();
      test_methods();
      test_errors();
      test_abort();
      report_and_stop();
   end
endmodule
